// >>> hdl/pmcfg_pkg.sv
// Constants and carrier types for the mode setting 2/3 configuration registers
package pmcfg_pkg;

  // ---------------------------------------------------------------
  // Register map and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] PMCFG_MODE2_ADDR = 8'h2D;
  localparam logic [7:0] PMCFG_MODE3_ADDR = 8'h2E;
  localparam logic [7:0] PMCFG_MODE2_RST = 8'h0C;
  localparam logic [7:0] PMCFG_MODE3_RST = 8'h1C;
  localparam logic [7:0] PMCFG_UNMAPPED_DATA = 8'h00;

  // ---------------------------------------------------------------
  // Operating modes
  // ---------------------------------------------------------------
  localparam logic [1:0] PMCFG_MODE0 = 2'h0;
  localparam logic [1:0] PMCFG_MODE2 = 2'h2;
  localparam logic [1:0] PMCFG_MODE3 = 2'h3;

  // ---------------------------------------------------------------
  // Watchdog period codes and periods in seconds
  // ---------------------------------------------------------------
  localparam logic [1:0] PMCFG_WD_OFF = 2'h0;
  localparam logic [1:0] PMCFG_WD_CODE_16 = 2'h1;
  localparam logic [1:0] PMCFG_WD_CODE_32 = 2'h2;
  localparam logic [6:0] PMCFG_WD_16_S = 7'h10;
  localparam logic [6:0] PMCFG_WD_32_S = 7'h20;
  localparam logic [6:0] PMCFG_WD_64_S = 7'h40;
  localparam logic [6:0] PMCFG_WD_NONE_S = 7'h00;

  // ---------------------------------------------------------------
  // Voltage code arithmetic, in millivolts
  // ---------------------------------------------------------------
  localparam int PMCFG_MV_W = 12;
  localparam logic [11:0] PMCFG_STEP_MV = 12'h019;
  localparam logic [11:0] PMCFG_LINREG_BASE_MV = 12'h5DC;
  localparam logic [11:0] PMCFG_LINREG_OFFSET_MV = 12'h4B0;
  localparam logic [5:0] PMCFG_LINREG_MAX_CODE = 6'h18;
  localparam logic [11:0] PMCFG_CORE_BASE_MV = 12'h1F4;
  localparam logic [5:0] PMCFG_CORE_MAX_CODE = 6'h28;
  localparam logic [5:0] PMCFG_CORE_FIXED_CODE = 6'h3F;
  localparam logic [11:0] PMCFG_CORE_FIXED_MV = 12'h708;
  localparam logic [11:0] PMCFG_RAIL_IDLE_MV = 12'h000;

  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0] wd_period;
    logic offset_sel;
    logic [4:0] code;
  } pmcfg_mode2_t;

  typedef struct packed {
    logic ship_en;
    logic src_sel;
    logic [5:0] code;
  } pmcfg_mode3_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pmcfg_req_t;

endpackage : pmcfg_pkg

// >>> hdl/pmcfg_sync.sv
// Two flip-flop synchroniser for the external mode select pins
`timescale 1ns/100ps
module pmcfg_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // Asynchronous in, synchronous out
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta;

  // ---------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------
  if (W < 1) begin : g_bad_w
    $error("pmcfg_sync: W must be at least 1");
  end

  // Stage one feeds stage two only
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      meta <= '0;
      sync_o <= '0;
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end

endmodule : pmcfg_sync

// >>> hdl/pmcfg_regs.sv
// Mode setting 2 part 3 and mode setting 3 part 0 configuration registers
//
// Behaviour
// - Watchdog period code 00 off, 01 16 s, 10 32 s, 11 64 s.
// - Linear regulator offset bit adds 0 V or 1.2 V to coded voltage.
// - Linear regulator code 0 is 1.500 V, +25 mV, clamped at 2.100 V.
// - Ship enable bit 1 enters ship mode, 0 stays out.
// - Source select 0 takes mode from register bits, ignores pins.
// - Source select 1 takes mode from pins while in mode 3, ignores register bits.
// - Core buck code 0 is 0.500 V, +25 mV to 1.500 V; reset 1.200 V.
// - Core codes 101001-111110 give 1.5 V; all ones gives 1.8 V.
// - Both registers read back last written value or reset value.
`timescale 1ns/100ps
module pmcfg_regs
  import pmcfg_pkg::*;
#(
  parameter int MV_W = 12
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // Register port from the serial target
  input wire pmcfg_pkg::pmcfg_req_t req_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  // Mode request sources
  input wire logic mode_reg_bit_a_i,
  input wire logic mode_reg_bit_b_i,
  input wire logic mode_select_pin_a_i,
  input wire logic mode_select_pin_b_i,
  // Controls toward the power stages
  output logic [1:0] active_mode_o,
  output logic ship_mode_o,
  output logic watchdog_en_o,
  output logic [6:0] watchdog_period_s_o,
  output logic [MV_W-1:0] sys_linreg_mv_o,
  output logic [MV_W-1:0] core_buck_mv_o
);
  import pmcfg_pkg::*;

  // ---------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------
  if (MV_W < PMCFG_MV_W) begin : g_bad_mv_w
    $error("pmcfg_regs: MV_W too narrow for 3.3 V in millivolts");
  end

  pmcfg_mode2_t mode2;
  pmcfg_mode3_t mode3;
  logic [1:0] pins_sync;
  logic [1:0] active_mode;
  logic [1:0] next_active_mode;
  logic [11:0] linreg_mv;
  logic [11:0] core_mv;
  logic [6:0] wd_secs;

  // Clamp a code to its top step, then scale into millivolts
  function automatic logic [11:0] code_to_mv(input logic [11:0] base,
                                             input logic [5:0] code,
                                             input logic [5:0] max_code);
    logic [11:0] steps;
    steps = {6'h00, (code > max_code) ? max_code : code};
    return 12'(base + steps * PMCFG_STEP_MV);
  endfunction : code_to_mv

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------

  // Mode setting 2 part 3 storage
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      mode2 <= PMCFG_MODE2_RST;
    end else if (req_i.wr && req_i.addr == PMCFG_MODE2_ADDR) begin
      mode2 <= req_i.wdata;
    end
  end

  // Mode setting 3 part 0 storage
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      mode3 <= PMCFG_MODE3_RST;
    end else if (req_i.wr && req_i.addr == PMCFG_MODE3_ADDR) begin
      mode3 <= req_i.wdata;
    end
  end

  // Registered read data, zero for unmapped addresses
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      rdata_o <= PMCFG_UNMAPPED_DATA;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= req_i.rd;
      if (req_i.rd) begin
        case (req_i.addr)
          PMCFG_MODE2_ADDR: rdata_o <= mode2;
          PMCFG_MODE3_ADDR: rdata_o <= mode3;
          default: rdata_o <= PMCFG_UNMAPPED_DATA;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Operating mode selection
  // ---------------------------------------------------------------

  // Mode select pins arrive from outside the clock domain
  pmcfg_sync #(
    .W(2)
  ) u_pin_sync (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .async_i({mode_select_pin_b_i, mode_select_pin_a_i}),
    .sync_o(pins_sync)
  );

  // Source of the next mode while in mode setting 3
  always_comb begin
    next_active_mode = {mode_reg_bit_b_i, mode_reg_bit_a_i};
    if (active_mode == PMCFG_MODE3 && mode3.src_sel) begin
      next_active_mode = pins_sync;
    end
  end

  // Active mode register
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      active_mode <= PMCFG_MODE0;
    end else begin
      active_mode <= next_active_mode;
    end
  end

  // ---------------------------------------------------------------
  // Field decoding
  // ---------------------------------------------------------------

  // Watchdog period in seconds
  always_comb begin
    case (mode2.wd_period)
      PMCFG_WD_OFF: wd_secs = PMCFG_WD_NONE_S;
      PMCFG_WD_CODE_16: wd_secs = PMCFG_WD_16_S;
      PMCFG_WD_CODE_32: wd_secs = PMCFG_WD_32_S;
      default: wd_secs = PMCFG_WD_64_S;
    endcase
  end

  // Linear regulator target with optional offset
  always_comb begin
    linreg_mv = code_to_mv(PMCFG_LINREG_BASE_MV, {1'b0, mode2.code},
                           PMCFG_LINREG_MAX_CODE);
    if (mode2.offset_sel) begin
      linreg_mv = 12'(linreg_mv + PMCFG_LINREG_OFFSET_MV);
    end
  end

  // Core buck target, all ones is the fixed rail
  always_comb begin
    core_mv = code_to_mv(PMCFG_CORE_BASE_MV, mode3.code, PMCFG_CORE_MAX_CODE);
    if (mode3.code == PMCFG_CORE_FIXED_CODE) begin
      core_mv = PMCFG_CORE_FIXED_MV;
    end
  end

  // ---------------------------------------------------------------
  // Output registers
  // ---------------------------------------------------------------

  // Mode setting 2 controls, idle outside mode 2
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      watchdog_en_o <= 1'b0;
      watchdog_period_s_o <= PMCFG_WD_NONE_S;
      sys_linreg_mv_o <= MV_W'(PMCFG_RAIL_IDLE_MV);
    end else if (active_mode == PMCFG_MODE2) begin
      watchdog_en_o <= (mode2.wd_period != PMCFG_WD_OFF);
      watchdog_period_s_o <= wd_secs;
      sys_linreg_mv_o <= MV_W'(linreg_mv);
    end else begin
      watchdog_en_o <= 1'b0;
      watchdog_period_s_o <= PMCFG_WD_NONE_S;
      sys_linreg_mv_o <= MV_W'(PMCFG_RAIL_IDLE_MV);
    end
  end

  // Mode setting 3 controls, idle outside mode 3
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      ship_mode_o <= 1'b0;
      core_buck_mv_o <= MV_W'(PMCFG_RAIL_IDLE_MV);
    end else if (active_mode == PMCFG_MODE3) begin
      ship_mode_o <= mode3.ship_en;
      core_buck_mv_o <= MV_W'(core_mv);
    end else begin
      ship_mode_o <= 1'b0;
      core_buck_mv_o <= MV_W'(PMCFG_RAIL_IDLE_MV);
    end
  end

  // Mode indication
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      active_mode_o <= PMCFG_MODE0;
    end else begin
      active_mode_o <= next_active_mode;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  // One clock domain, checks idle while reset is low
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  // Decoded outputs of both mode settings, mode source and mode 3 read back
  wd_enable_a: assert property ($past(nrst_i) |-> watchdog_en_o ==
      ($past(active_mode) == PMCFG_MODE2 && $past(mode2.wd_period) != PMCFG_WD_OFF))
    else $error("watchdog enable does not follow period code");
  wd_longest_a: assert property ((active_mode == PMCFG_MODE2 && mode2.wd_period == 2'h3)
      |=> watchdog_period_s_o == PMCFG_WD_64_S)
    else $error("watchdog code 11 not 64 s");
  linreg_offset_a: assert property ((active_mode == PMCFG_MODE2 && mode2.offset_sel &&
      mode2.code == 5'h00) |=> sys_linreg_mv_o == MV_W'(12'hA8C))
    else $error("offset code 0 not 2.7 V");
  linreg_clamp_a: assert property ((active_mode == PMCFG_MODE2 && !mode2.offset_sel &&
      mode2.code > 5'h18) |=> sys_linreg_mv_o == MV_W'(12'h834))
    else $error("linear regulator clamp not 2.1 V");
  ship_mode_a: assert property ($past(nrst_i) |-> ship_mode_o ==
      ($past(active_mode) == PMCFG_MODE3 && $past(mode3.ship_en)))
    else $error("ship mode does not follow enable bit");
  src_register_a: assert property ((active_mode == PMCFG_MODE3 && !mode3.src_sel) |=>
      active_mode == $past({mode_reg_bit_b_i, mode_reg_bit_a_i}))
    else $error("mode not taken from register bits");
  src_pins_a: assert property ((active_mode == PMCFG_MODE3 && mode3.src_sel) |=>
      active_mode == $past(pins_sync))
    else $error("mode not taken from pins");
  core_base_a: assert property ((active_mode == PMCFG_MODE3 && mode3.code == 6'h00)
      |=> core_buck_mv_o == MV_W'(12'h1F4))
    else $error("core code 0 not 0.5 V");
  core_fixed_a: assert property ((active_mode == PMCFG_MODE3 && mode3.code == 6'h3F)
      |=> core_buck_mv_o == MV_W'(12'h708))
    else $error("core all ones not 1.8 V");
  core_upper_a: assert property ((active_mode == PMCFG_MODE3 && mode3.code > 6'h28 &&
      mode3.code < 6'h3F) |=> core_buck_mv_o == MV_W'(12'h5DC))
    else $error("core upper codes not 1.5 V");
  read_back_a: assert property ((req_i.rd && req_i.addr == PMCFG_MODE3_ADDR) |=>
      rvalid_o && rdata_o == $past(mode3))
    else $error("mode 3 register read back wrong");
  mode2_idle_a: assert property ((active_mode != PMCFG_MODE2) |=>
      !watchdog_en_o && sys_linreg_mv_o == MV_W'(PMCFG_RAIL_IDLE_MV))
    else $error("mode 2 fields act outside mode 2");
  mode3_idle_a: assert property ((active_mode != PMCFG_MODE3) |=>
      !ship_mode_o && core_buck_mv_o == MV_W'(PMCFG_RAIL_IDLE_MV))
    else $error("mode 3 fields act outside mode 3");

  // Watchdog and linear regulator codes
  wd_off_a: assert property ((active_mode == PMCFG_MODE2 && mode2.wd_period == 2'h0)
      |=> !watchdog_en_o && watchdog_period_s_o == PMCFG_WD_NONE_S)
    else $error("watchdog code 00 not off");
  wd_short_a: assert property ((active_mode == PMCFG_MODE2 && mode2.wd_period == 2'h1)
      |=> watchdog_en_o && watchdog_period_s_o == PMCFG_WD_16_S)
    else $error("watchdog code 01 not 16 s");
  wd_middle_a: assert property ((active_mode == PMCFG_MODE2 && mode2.wd_period == 2'h2)
      |=> watchdog_en_o && watchdog_period_s_o == PMCFG_WD_32_S)
    else $error("watchdog code 10 not 32 s");
  linreg_mid_a: assert property ((active_mode == PMCFG_MODE2 && !mode2.offset_sel &&
      mode2.code == 5'h0C) |=> sys_linreg_mv_o == MV_W'(12'h708))
    else $error("linear regulator code 0C not 1.8 V");

  // Core buck and ship enable
  core_reset_a: assert property (!$past(nrst_i) |-> mode3.code == 6'h1C)
    else $error("core code reset value not 1.2 V");
  core_mid_a: assert property ((active_mode == PMCFG_MODE3 && mode3.code == 6'h1C)
      |=> core_buck_mv_o == MV_W'(12'h4B0))
    else $error("core code 1C not 1.2 V");
  ship_off_a: assert property ((active_mode == PMCFG_MODE3 && !mode3.ship_en)
      |=> !ship_mode_o)
    else $error("ship mode without enable bit");

  // Register port
  write_store_a: assert property ((req_i.wr && req_i.addr == PMCFG_MODE2_ADDR) |=>
      mode2 == $past(req_i.wdata))
    else $error("mode 2 register write lost");
  unmapped_read_a: assert property ((req_i.rd && req_i.addr != PMCFG_MODE2_ADDR &&
      req_i.addr != PMCFG_MODE3_ADDR) |=> rvalid_o && rdata_o == PMCFG_UNMAPPED_DATA)
    else $error("unmapped read not zero");
  rvalid_pulse_a: assert property (!req_i.rd |=> !rvalid_o)
    else $error("read valid without a read");

  // Main scenarios reached
  ship_entry_c: cover property (active_mode == PMCFG_MODE3 ##1 ship_mode_o);
  pin_control_c: cover property (active_mode == PMCFG_MODE3 && mode3.src_sel ##1
      active_mode == PMCFG_MODE0);
  wd_long_c: cover property (watchdog_period_s_o == PMCFG_WD_64_S);
  linreg_offset_c: cover property (active_mode == PMCFG_MODE2 && mode2.offset_sel);
  core_fixed_c: cover property (core_buck_mv_o == MV_W'(PMCFG_CORE_FIXED_MV));

endmodule : pmcfg_regs

// >>> test/pmcfg_host.sv
// Host side register access model for the configuration registers
`timescale 1ns/100ps
module pmcfg_host (
  // Clock
  input wire logic sys_clk_i,
  // Register port toward the device
  output pmcfg_pkg::pmcfg_req_t req_o,
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i
);
  import pmcfg_pkg::*;

  // Idle port from time zero
  initial begin
    req_o = '0;
  end

  // One-cycle write pulse, launched after an edge
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge sys_clk_i);
    req_o <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    @(posedge sys_clk_i);
    req_o <= '0;
  endtask : write_reg

  // Read pulse, data taken while the answer stands
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic ok);
    @(posedge sys_clk_i);
    req_o <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
    @(posedge sys_clk_i);
    req_o <= '0;
    #1;
    ok = rvalid_i;
    data = rdata_i;
  endtask : read_reg
endmodule : pmcfg_host

// >>> test/pmcfg_regs_tb.sv
// Self-checking testbench for the mode setting configuration registers
`timescale 1ns/100ps
module pmcfg_regs_tb;
  import pmcfg_pkg::*;

  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic sys_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic bit_a = 1'b0;
  logic bit_b = 1'b0;
  logic pin_a = 1'b0;
  logic pin_b = 1'b0;
  pmcfg_req_t req;
  logic [7:0] rdata;
  logic rvalid;
  logic [1:0] act_mode;
  logic ship;
  logic wd_en;
  logic [6:0] wd_s;
  logic [11:0] lin_mv;
  logic [11:0] core_mv;
  int error_cnt = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [7:0] rd;
  logic ok;
  logic [4:0] lin_codes [5] = '{5'h0C, 5'h00, 5'h18, 5'h19, 5'h1F};
  logic [5:0] core_codes [6] = '{6'h00, 6'h1C, 6'h28, 6'h29, 6'h3E, 6'h3F};

  // Clock and instances
  always #5 sys_clk_i = ~sys_clk_i;

  pmcfg_host u_host (.sys_clk_i(sys_clk_i), .req_o(req), .rdata_i(rdata), .rvalid_i(rvalid));

  pmcfg_regs u_dut (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .req_i(req), .rdata_o(rdata), .rvalid_o(rvalid),
    .mode_reg_bit_a_i(bit_a), .mode_reg_bit_b_i(bit_b),
    .mode_select_pin_a_i(pin_a), .mode_select_pin_b_i(pin_b),
    .active_mode_o(act_mode), .ship_mode_o(ship), .watchdog_en_o(wd_en),
    .watchdog_period_s_o(wd_s), .sys_linreg_mv_o(lin_mv), .core_buck_mv_o(core_mv)
  );

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic test_done;
    if (error_cnt == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done

  // Read with the valid pulse checked as well
  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
    u_host.read_reg(addr, rd, ok);
    chk(ok, 1'b1);
    chk(rd, exp);
  endtask : rd_chk

  // Let pins, mode and outputs settle
  task automatic settle;
    repeat (5) @(posedge sys_clk_i);
    #1;
  endtask : settle

  task automatic set_bits(input logic [1:0] m);
    @(posedge sys_clk_i);
    bit_a <= m[0];
    bit_b <= m[1];
    settle();
  endtask : set_bits

  // Cycle ceiling against hangs
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      error_cnt++;
      test_done();
    end
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (10) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    // Reset values and an unmapped place
    rd_chk(PMCFG_MODE2_ADDR, 8'h0C);
    rd_chk(PMCFG_MODE3_ADDR, 8'h1C);
    rd_chk(8'h2F, 8'h00);
    u_host.write_reg(PMCFG_MODE2_ADDR, 8'hA5);
    u_host.write_reg(PMCFG_MODE3_ADDR, 8'h5A);
    rd_chk(PMCFG_MODE2_ADDR, 8'hA5);
    rd_chk(PMCFG_MODE3_ADDR, 8'h5A);
    // Mode 2: watchdog codes, offset and linear regulator clamp
    set_bits(2'b10);
    chk(act_mode, PMCFG_MODE2);
    for (int i = 0; i < 5; i++) begin
      u_host.write_reg(PMCFG_MODE2_ADDR, {i[1:0], i[0], lin_codes[i]});
      settle();
      chk(wd_en, i[1:0] != 2'b00);
      chk(wd_s, (i[1:0] == 0) ? 0 : (12'd8 << i[1:0]));
      chk(lin_mv, 1500 + 25 * ((lin_codes[i] > 24) ? 24 : lin_codes[i])
          + (i[0] ? 1200 : 0));
      chk(core_mv, 12'h000);
      chk(ship, 1'b0);
    end
    // Mode 3: core buck codes, ship enable
    set_bits(2'b11);
    for (int i = 0; i < 6; i++) begin
      u_host.write_reg(PMCFG_MODE3_ADDR, {i[0], 1'b0, core_codes[i]});
      settle();
      chk(core_mv, (core_codes[i] == 6'h3F) ? 12'd1800
          : 500 + 25 * ((core_codes[i] > 40) ? 40 : core_codes[i]));
      chk(ship, i[0]);
      chk(act_mode, PMCFG_MODE3);
      chk(lin_mv, 12'h000);
      chk(wd_en, 1'b0);
    end
    // Register source: pins ignored
    @(posedge sys_clk_i);
    pin_b <= 1'b1;
    settle();
    chk(act_mode, PMCFG_MODE3);
    // Pin source: register bits ignored, pins steer the mode
    @(posedge sys_clk_i);
    pin_a <= 1'b1;
    u_host.write_reg(PMCFG_MODE3_ADDR, 8'h5C);
    set_bits(2'b00);
    chk(act_mode, PMCFG_MODE3);
    @(posedge sys_clk_i);
    pin_a <= 1'b0;
    pin_b <= 1'b0;
    settle();
    chk(act_mode, PMCFG_MODE0);
    chk(core_mv, 12'h000);
    rd_chk(PMCFG_MODE3_ADDR, 8'h5C);
    test_done();
  end
endmodule : pmcfg_regs_tb
